// ---- hdl/gcr_consts.svh ----
// Constants for the general bus command responder: command bytes, timing, defaults.
// Assumes the includer compiles it once per unit; guarded against double inclusion.
// Function
// - IFC forces local, talker and listener idle
// - IFC turns off talk and listen lights
// - Lockout blocks front panel except power
// - Lockout accepted only while REN asserted
// - Lockout cancelled only by REN false
// - Addressed go-to-local leaves remote, lamp off
// - Lockout survives go-to-local until REN false
// - Universal clear acts whether addressed or not
// - Clears restore user or factory defaults
// - Factory: DC volts, 1000 V, 100 ms, filters
// - Factory bus: prefix, no service request, CR LF
// - Selective clear only when addressed as listener
// - Trigger starts reading only in bus-trigger modes
// - One-shot bus mode: one reading per trigger
// - REN plus own talk address: remote, talker
// - REN alone never makes device remote
// - Bus trigger modes are continuous and one-shot
`ifndef GCR_CONSTS_SVH
`define GCR_CONSTS_SVH

// ----------------------------------------
// Command bytes
// ----------------------------------------
`define GCR_CMD_GTL        8'h01
`define GCR_CMD_SDC        8'h04
`define GCR_CMD_GET        8'h08
`define GCR_CMD_LLO        8'h11
`define GCR_CMD_DCL        8'h14
`define GCR_CMD_UNL        8'h3f
`define GCR_CMD_UNT        8'h5f
`define GCR_LAG_BASE       3'h1
`define GCR_TAG_BASE       3'h2
`define GCR_ADDR_MSB       4
`define GCR_GROUP_LSB      5

// ----------------------------------------
// Timing
// ----------------------------------------
`define GCR_CLK_MHZ        25
`define GCR_IFC_MIN_US     100

// ----------------------------------------
// Factory default setting codes and bus trigger mode codes
// ----------------------------------------
`define GCR_DEF_FUNCTION   4'h0
`define GCR_DEF_RANGE      3'h5
`define GCR_DEF_RATE       3'h3
`define GCR_DEF_TRIGGER    3'h6
`define GCR_DEF_DIG_FILT   1'b0
`define GCR_DEF_EXP_FILT   1'b1
`define GCR_DEF_ZERO       1'b0
`define GCR_DEF_PREFIX     1'b1
`define GCR_DEF_SRQ_EN     1'b0
`define GCR_DEF_TERM       2'h0
`define GCR_TRIG_CONT_BUS  3'h2
`define GCR_TRIG_ONE_BUS   3'h3

`endif

// ---- hdl/gcr_pkg.sv ----
// Types shared by the general bus command responder.
// Assumes gcr_consts.svh supplies the numbers.
package gcr_pkg;

	typedef struct packed
	{
		logic [3:0] function_sel;
		logic [2:0] range_sel;
		logic [2:0] rate_sel;
		logic [2:0] trigger_mode;
		logic       dig_filter;
		logic       exp_filter;
		logic       zero_en;
		logic       prefix_en;
		logic       srq_en;
		logic [1:0] terminator;
	} settings_t;

	typedef enum logic [1:0]
	{
		LOC_S  = 2'b00,
		REM_S  = 2'b01,
		LWLS_S = 2'b10,
		RWLS_S = 2'b11
	} rl_state_t;

endpackage

// ---- hdl/gcr_sync.sv ----
// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
// Assumes an asynchronous pin on the input and one system clock.
`timescale 1ns/1ps
`default_nettype none
module gcr_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output var  logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [WIDTH-1:0] lvl_d;

	always_comb
	begin
		lvl_d = lvl_q;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_q[i] == s3_q[i])
				lvl_d[i] = s3_q[i];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end
		else
		begin
			s1_q  <= pin_i;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level_o = lvl_q;
endmodule
`default_nettype wire

// ---- hdl/gcr_top.sv ----
// General bus command responder: remote/local, lockout, clears, trigger, IFC.
// Assumes the acceptor handshake delivers each bus byte as a one-cycle strobe;
// ATN/REN/IFC are raw bus levels (active high here) and are synchronised inside.
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
module gcr_top
	import gcr_pkg::*;
#(
	parameter logic [4:0] MY_ADDR   = 5'h0a,
	parameter int         IFC_US    = `GCR_IFC_MIN_US
)
(
	// Clock and reset
	input  wire logic       REF_CLK_I,
	input  wire logic       RST_N_I,
	// Bus control lines
	input  wire logic       ATN_I,
	input  wire logic       REN_I,
	input  wire logic       IFC_I,
	// Byte from acceptor handshake
	input  wire logic       BYTE_STB_I,
	input  wire logic [7:0] BYTE_I,
	// Instrument side
	input  wire logic       USE_USER_DEF_I,
	input  wire settings_t  USER_DEF_I,
	input  wire logic       SET_LOAD_I,
	input  wire settings_t  SET_I,
	input  wire logic [7:0] PANEL_KEYS_I,
	// Status and indicators
	output logic            REMOTE_O,
	output logic            LOCKOUT_O,
	output logic            TALK_O,
	output logic            LISTEN_O,
	output logic [7:0]      PANEL_KEYS_O,
	output settings_t       SETTINGS_O,
	output logic            CLEAR_O,
	output logic            TRIGGER_O,
	output logic            DATA_STB_O,
	output logic [7:0]      DATA_O
);
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int IFC_CYC_RAW = IFC_US * `GCR_CLK_MHZ;
	localparam int IFC_CYC     = (IFC_CYC_RAW < 1) ? 1 : IFC_CYC_RAW;
	localparam int CW          = $clog2(IFC_CYC + 1);

	// ----------------------------------------
	// Synchronised control lines
	// ----------------------------------------
	logic [2:0] lines;
	logic       atn, ren, ifc;

	gcr_sync #(.WIDTH(3)) u_sync
	(
		.clk_i   (REF_CLK_I),
		.rst_n_i (RST_N_I),
		.pin_i   ({ATN_I, REN_I, IFC_I}),
		.level_o (lines)
	);
	assign {atn, ren, ifc} = lines;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic cmd, dat;
	logic is_mla, is_mta, is_unl, is_unt, is_ota;
	logic ifc_act;

	always_comb
	begin
		cmd    = BYTE_STB_I && atn;
		dat    = BYTE_STB_I && !atn;
		is_mla = BYTE_I[7:`GCR_GROUP_LSB] == `GCR_LAG_BASE && BYTE_I[`GCR_ADDR_MSB:0] == MY_ADDR;
		is_mta = BYTE_I[7:`GCR_GROUP_LSB] == `GCR_TAG_BASE && BYTE_I[`GCR_ADDR_MSB:0] == MY_ADDR;
		is_unl = BYTE_I == `GCR_CMD_UNL;
		is_unt = BYTE_I == `GCR_CMD_UNT;
		is_ota = BYTE_I[7:`GCR_GROUP_LSB] == `GCR_TAG_BASE && !is_mta && !is_unt;
	end

	// ----------------------------------------
	// IFC qualification
	// ----------------------------------------
	// Only a pulse held for the full minimum counts; short glitches are ignored.
	logic [CW-1:0] ifc_cnt_q, ifc_cnt_d;

	always_comb
	begin
		ifc_cnt_d = ifc_cnt_q;
		if (!ifc)
			ifc_cnt_d = '0;
		else if (ifc_cnt_q != CW'(IFC_CYC))
			ifc_cnt_d = ifc_cnt_q + CW'(1);
	end
	assign ifc_act = ifc_cnt_q == CW'(IFC_CYC);

	// ----------------------------------------
	// Addressing and remote/local state
	// ----------------------------------------
	logic      talk_q, talk_d, lstn_q, lstn_d;
	rl_state_t rl_q, rl_d;
	logic      addressed;

	assign addressed = lstn_q;

	always_comb
	begin
		talk_d = talk_q;
		lstn_d = lstn_q;
		rl_d   = rl_q;
		if (cmd)
		begin
			if (is_mta)
			begin
				talk_d = 1'b1;
				lstn_d = 1'b0;
			end
			else if (is_ota || is_unt)
				talk_d = 1'b0;
			if (is_mla)
			begin
				lstn_d = 1'b1;
				talk_d = 1'b0;
			end
			else if (is_unl)
				lstn_d = 1'b0;
		end
		case (rl_q)
			LOC_S:
			begin
				if (ren && cmd && (is_mla || is_mta))
					rl_d = REM_S;
				else if (ren && cmd && BYTE_I == `GCR_CMD_LLO)
					rl_d = LWLS_S;
			end
			REM_S:
			begin
				if (cmd && addressed && BYTE_I == `GCR_CMD_GTL)
					rl_d = LOC_S;
				else if (ren && cmd && BYTE_I == `GCR_CMD_LLO)
					rl_d = RWLS_S;
			end
			LWLS_S:
			begin
				if (ren && cmd && (is_mla || is_mta))
					rl_d = RWLS_S;
			end
			RWLS_S:
			begin
				if (cmd && addressed && BYTE_I == `GCR_CMD_GTL)
					rl_d = LWLS_S;
			end
			default:
				rl_d = LOC_S;
		endcase
		if (!ren)
			rl_d = LOC_S;
		if (ifc_act)
		begin
			talk_d = 1'b0;
			lstn_d = 1'b0;
			if (rl_d == RWLS_S)
				rl_d = LWLS_S;
			else if (rl_d == REM_S)
				rl_d = LOC_S;
		end
	end

	// ----------------------------------------
	// Clears, settings and trigger
	// ----------------------------------------
	settings_t set_q, set_d;
	logic      clr_q, clr_d, trg_q, trg_d, arm_q, arm_d;
	logic      dstb_q, dstb_d;
	logic [7:0] data_q, data_d;
	logic      do_clear, do_get;
	settings_t factory;

	always_comb
	begin
		factory.function_sel = `GCR_DEF_FUNCTION;
		factory.range_sel    = `GCR_DEF_RANGE;
		factory.rate_sel     = `GCR_DEF_RATE;
		factory.trigger_mode = `GCR_DEF_TRIGGER;
		factory.dig_filter   = `GCR_DEF_DIG_FILT;
		factory.exp_filter   = `GCR_DEF_EXP_FILT;
		factory.zero_en      = `GCR_DEF_ZERO;
		factory.prefix_en    = `GCR_DEF_PREFIX;
		factory.srq_en       = `GCR_DEF_SRQ_EN;
		factory.terminator   = `GCR_DEF_TERM;
	end

	always_comb
	begin
		do_clear = cmd && (BYTE_I == `GCR_CMD_DCL
			|| (BYTE_I == `GCR_CMD_SDC && addressed));
		do_get   = cmd && addressed && BYTE_I == `GCR_CMD_GET;
		set_d    = set_q;
		clr_d    = do_clear;
		trg_d    = 1'b0;
		arm_d    = arm_q;
		dstb_d   = dat && addressed;
		data_d   = dat ? BYTE_I : data_q;
		if (SET_LOAD_I)
			set_d = SET_I;
		if (do_clear)
			set_d = USE_USER_DEF_I ? USER_DEF_I : factory;
		if (do_get)
		begin
			if (set_q.trigger_mode == `GCR_TRIG_CONT_BUS)
			begin
				trg_d = 1'b1;
				arm_d = 1'b1;
			end
			else if (set_q.trigger_mode == `GCR_TRIG_ONE_BUS)
				trg_d = 1'b1;
		end
		// Continuous bus mode keeps reading after its first trigger;
		// a device clear or a change of mode stops it.
		if (do_clear || set_d.trigger_mode != `GCR_TRIG_CONT_BUS)
			arm_d = 1'b0;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			ifc_cnt_q <= '0;
		end
		else
		begin
			ifc_cnt_q <= ifc_cnt_d;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			talk_q    <= 1'b0;
			lstn_q    <= 1'b0;
			rl_q      <= LOC_S;
		end
		else
		begin
			talk_q    <= talk_d;
			lstn_q    <= lstn_d;
			rl_q      <= rl_d;
		end
	end

	// Reset values match the factory set, so power-up looks like a device clear with USE_USER_DEF_I low.
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			set_q     <= '{`GCR_DEF_FUNCTION, `GCR_DEF_RANGE, `GCR_DEF_RATE, `GCR_DEF_TRIGGER,
				`GCR_DEF_DIG_FILT, `GCR_DEF_EXP_FILT, `GCR_DEF_ZERO, `GCR_DEF_PREFIX,
				`GCR_DEF_SRQ_EN, `GCR_DEF_TERM};
			clr_q     <= 1'b0;
			trg_q     <= 1'b0;
			arm_q     <= 1'b0;
		end
		else
		begin
			set_q     <= set_d;
			clr_q     <= clr_d;
			trg_q     <= trg_d;
			arm_q     <= arm_d;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			dstb_q    <= 1'b0;
			data_q    <= 8'h00;
		end
		else
		begin
			dstb_q    <= dstb_d;
			data_q    <= data_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign REMOTE_O     = rl_q == REM_S || rl_q == RWLS_S;
	assign LOCKOUT_O    = rl_q == LWLS_S || rl_q == RWLS_S;
	assign TALK_O       = talk_q;
	assign LISTEN_O     = lstn_q;
	// Only the power switch is outside this path, so lockout masks every key.
	assign PANEL_KEYS_O = LOCKOUT_O ? 8'h00 : PANEL_KEYS_I;
	assign SETTINGS_O   = set_q;
	assign CLEAR_O      = clr_q;
	assign TRIGGER_O    = trg_q || arm_q;
	assign DATA_STB_O   = dstb_q;
	assign DATA_O       = data_q;
endmodule
`default_nettype wire

// ---- dv/gcr_ctrl_model.sv ----
// Bus controller model: drives ATN, REN, IFC and command or data bytes.
// Assumes one clock shared with the responder; requests change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module gcr_ctrl_model
(
	// Clock
	input  wire logic       clk_i,
	// Bus lines towards the responder
	output var  logic       atn_o,
	output var  logic       ren_o,
	output var  logic       ifc_o,
	output var  logic       stb_o,
	output var  logic [7:0] byte_o
);
	initial
	begin
		atn_o  = 1'b0;
		ren_o  = 1'b0;
		ifc_o  = 1'b0;
		stb_o  = 1'b0;
		byte_o = 8'h00;
	end
	// Settle time covers the pin synchroniser
	task automatic lines(input logic a, input logic r);
		@(posedge clk_i);
		atn_o <= a;
		ren_o <= r;
		repeat (6) @(posedge clk_i);
	endtask
	// Released data lines show the inverse so stale bytes cannot match
	task automatic put(input logic [7:0] b);
		@(posedge clk_i);
		stb_o  <= 1'b1;
		byte_o <= b;
		@(posedge clk_i);
		stb_o  <= 1'b0;
		byte_o <= ~b;
	endtask
	task automatic clear_if(input int n);
		@(posedge clk_i);
		ifc_o <= 1'b1;
		repeat (n) @(posedge clk_i);
		ifc_o <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// ---- dv/gcr_top_assertions.sv ----
// Checker for the general bus command responder, bound to its top.
// Assumes bus control lines are held steady around each command byte.
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
module gcr_top_assertions
	import gcr_pkg::*;
#(
	parameter logic [4:0] MY_ADDR = 5'h0a
)
(
	input wire logic       REF_CLK_I,
	input wire logic       RST_N_I,
	input wire logic       ATN_I,
	input wire logic       REN_I,
	input wire logic       BYTE_STB_I,
	input wire logic [7:0] BYTE_I,
	input wire logic       USE_USER_DEF_I,
	input wire logic [7:0] PANEL_KEYS_I,
	input wire logic       REMOTE_O,
	input wire logic       LOCKOUT_O,
	input wire logic       TALK_O,
	input wire logic       LISTEN_O,
	input wire logic [7:0] PANEL_KEYS_O,
	input wire settings_t  SETTINGS_O,
	input wire logic       CLEAR_O,
	input wire logic       TRIGGER_O,
	input wire logic       DATA_STB_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);
	a_keys_locked: assert property (LOCKOUT_O |-> PANEL_KEYS_O == 8'h00)
		else $error("panel keys pass during lockout");
	a_lockout_cause: assert property ($rose(LOCKOUT_O) |-> $past(BYTE_STB_I) && $past(BYTE_I) == 8'h11 && REN_I)
		else $error("lockout without command under remote enable");
	a_lockout_release: assert property ($fell(LOCKOUT_O) |-> !REN_I)
		else $error("lockout dropped with remote enable");
	a_remote_cause: assert property ($rose(REMOTE_O) |-> REN_I && ATN_I && $past(BYTE_STB_I)
		&& $past(BYTE_I[4:0]) == MY_ADDR && $past(BYTE_I[7:5]) inside {3'h1, 3'h2})
		else $error("remote without addressing");
	a_talk_address: assert property ($rose(TALK_O) |-> $past(BYTE_I) == {3'h2, MY_ADDR})
		else $error("talker without own talk address");
	a_clear_cause: assert property (CLEAR_O |-> $past(BYTE_STB_I) && ATN_I
		&& ($past(BYTE_I) == 8'h14 || $past(BYTE_I) == 8'h04 && $past(LISTEN_O)))
		else $error("clear without accepted clear command");
	a_clear_pulse: assert property (CLEAR_O && !BYTE_STB_I |=> !CLEAR_O)
		else $error("clear longer than one cycle");
	a_clear_factory: assert property (CLEAR_O && !$past(USE_USER_DEF_I) |-> SETTINGS_O.range_sel == `GCR_DEF_RANGE
		&& SETTINGS_O.rate_sel == `GCR_DEF_RATE && SETTINGS_O.function_sel == `GCR_DEF_FUNCTION)
		else $error("factory settings not restored");
	a_trig_mode: assert property ($rose(TRIGGER_O) |-> SETTINGS_O.trigger_mode inside {3'h2, 3'h3})
		else $error("trigger outside bus trigger modes");
	a_one_shot: assert property (TRIGGER_O && SETTINGS_O.trigger_mode == 3'h3 && !BYTE_STB_I |=> !TRIGGER_O)
		else $error("one-shot trigger repeated");
	a_data_no_atn: assert property (DATA_STB_O |-> !ATN_I && $past(BYTE_STB_I))
		else $error("data strobe under attention");
endmodule
bind gcr_top gcr_top_assertions #(.MY_ADDR(MY_ADDR)) i_gcr_top_assertions (.*);
`default_nettype wire

// ---- dv/bus_general_command_responder_tb_top.sv ----
// Self-checking bench: controller model drives the bus, a reference model predicts outputs.
// Assumes gcr_top with a shortened interface clear count.
`timescale 1ns/1ps
`default_nettype none
`include "gcr_consts.svh"
module bus_general_command_responder_tb_top
	import gcr_pkg::*;
;
	logic      clk, rst_n, atn, ren, ifc, stb, uud, sld;
	logic      rem, llo, tlk, lsn, clr, trg, dst;
	logic [7:0] byt, keys, pko, dto;
	settings_t udef, set_v, fac, so, m_set;
	int        err_count, checked, m_rem, m_llo, m_tlk, m_lsn, m_clr, m_trg, m_dst, m_lvl;

	gcr_ctrl_model i_gcr_ctrl_model
	(
		.clk_i(clk), .atn_o(atn), .ren_o(ren), .ifc_o(ifc), .stb_o(stb), .byte_o(byt)
	);
	gcr_top #(.IFC_US(1)) i_gcr_top
	(
		.REF_CLK_I(clk), .RST_N_I(rst_n), .ATN_I(atn), .REN_I(ren), .IFC_I(ifc),
		.BYTE_STB_I(stb), .BYTE_I(byt), .USE_USER_DEF_I(uud), .USER_DEF_I(udef),
		.SET_LOAD_I(sld), .SET_I(set_v), .PANEL_KEYS_I(keys), .REMOTE_O(rem),
		.LOCKOUT_O(llo), .TALK_O(tlk), .LISTEN_O(lsn), .PANEL_KEYS_O(pko),
		.SETTINGS_O(so), .CLEAR_O(clr), .TRIGGER_O(trg), .DATA_STB_O(dst), .DATA_O(dto)
	);

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Pulses are looked at in the one cycle they stand
	task automatic chk_all();
		#1;
		chk("remote", rem, m_rem);
		chk("lockout", llo, m_llo);
		chk("talk", tlk, m_tlk);
		chk("listen", lsn, m_lsn);
		chk("keys", pko, m_llo ? 8'h00 : keys);
		chk("settings", so, m_set);
		chk("clear", clr, m_clr);
		chk("trigger", trg, m_trg | m_lvl);
		chk("data_stb", dst, m_dst);
		m_clr = 0;
		m_trg = 0;
		m_dst = 0;
	endtask
	task automatic cmd(input logic [7:0] b);
		int d;
		m_dst = !atn && m_lsn;
		d = m_dst;
		if (atn)
		begin
			if (b == 8'h2a || b == 8'h4a)
			begin
				m_lsn = (b == 8'h2a);
				m_tlk = (b == 8'h4a);
				m_rem = m_rem | ren;
			end
			if (b == 8'h3f)
				m_lsn = 0;
			if (b == 8'h11)
				m_llo = m_llo | ren;
			if (b == 8'h01 && m_lsn)
				m_rem = 0;
			m_clr = (b == 8'h14) || (b == 8'h04 && m_lsn);
			if (m_clr)
				m_set = uud ? udef : fac;
			if (m_clr)
				m_lvl = 0;
			m_trg = b == 8'h08 && m_lsn && m_set.trigger_mode == 3'h3;
			if (b == 8'h08 && m_lsn && m_set.trigger_mode == 3'h2)
				m_lvl = 1;
		end
		i_gcr_ctrl_model.put(b);
		chk_all();
		if (d)
			chk("data", dto, b);
	endtask
	task automatic load(input logic [2:0] m);
		settings_t t;
		t = 20'($urandom);
		t.trigger_mode = m;
		@(posedge clk);
		set_v <= t;
		sld <= 1'b1;
		keys <= 8'($urandom);
		@(posedge clk);
		sld <= 1'b0;
		if (t.trigger_mode != m_set.trigger_mode)
			m_lvl = 0;
		m_set = t;
		chk_all();
	endtask

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#200000;
		err_count++;
		report_and_stop();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		err_count = 0;
		checked = 0;
		rst_n = 1'b0;
		uud = 1'b0;
		sld = 1'b0;
		set_v = '0;
		void'($urandom(32'hb283));
		udef = 20'($urandom);
		keys = 8'($urandom);
		fac = '{`GCR_DEF_FUNCTION, `GCR_DEF_RANGE, `GCR_DEF_RATE, `GCR_DEF_TRIGGER, `GCR_DEF_DIG_FILT,
			`GCR_DEF_EXP_FILT, `GCR_DEF_ZERO, `GCR_DEF_PREFIX, `GCR_DEF_SRQ_EN, `GCR_DEF_TERM};
		m_set = fac;
		{m_rem, m_llo, m_tlk, m_lsn, m_clr, m_trg, m_dst, m_lvl} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		chk_all();
		i_gcr_ctrl_model.lines(1'b1, 1'b0);
		cmd(8'h2a);
		cmd(8'h11);
		i_gcr_ctrl_model.lines(1'b1, 1'b1);
		chk_all();
		cmd(8'h4a);
		cmd(8'h11);
		cmd(8'h2a);
		cmd(8'h01);
		for (int m = 0; m < 8; m++)
		begin
			load(3'(m));
			cmd(8'h08);
			@(posedge clk);
			chk_all();
		end
		@(posedge clk) uud <= 1'b1;
		cmd(8'h3f);
		cmd(8'h04);
		cmd(8'h2a);
		cmd(8'h04);
		@(posedge clk) uud <= 1'b0;
		cmd(8'h3f);
		cmd(8'h14);
		cmd(8'h2a);
		i_gcr_ctrl_model.lines(1'b0, 1'b1);
		cmd(8'($urandom));
		cmd(8'h14);
		i_gcr_ctrl_model.lines(1'b1, 1'b1);
		cmd(8'h4a);
		i_gcr_ctrl_model.clear_if(10);
		chk_all();
		i_gcr_ctrl_model.clear_if(40);
		m_tlk = 0;
		m_lsn = 0;
		m_rem = 0;
		chk_all();
		cmd(8'h2a);
		i_gcr_ctrl_model.lines(1'b1, 1'b0);
		m_rem = 0;
		m_llo = 0;
		chk_all();
		report_and_stop();
	end
endmodule
`default_nettype wire
